/* File: src/dscg_top.sv */
// Deep-sleep clock gating control with run, sleep and deep-sleep gate
// registers behind an AXI4-Lite slave, per-unit clock enables and a
// bus fault check for accesses to unclocked units.
// Assumes mode inputs and the access port come from logic on aclk.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dscg_defs.svh"
module dscg_top
   import dscg_pkg::*;
#(
   parameter int ADDR_W    = 12,            // AXI address width
   parameter int NUM_UNITS = `DSCG_NUM_UNITS // Gated units
)
(
   input  wire logic                 aclk,            // System clock, 25 MHz
   input  wire logic                 aresetn,         // Synchronous reset, active low
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,    // Write address
   input  wire logic                 s_axi_awvalid,   // Write address valid
   output logic                      s_axi_awready,   // Write address ready
   // AXI4-Lite write data
   input  wire logic [31:0]          s_axi_wdata,     // Write data
   input  wire logic [3:0]           s_axi_wstrb,     // Byte strobes
   input  wire logic                 s_axi_wvalid,    // Write data valid
   output logic                      s_axi_wready,    // Write data ready
   // AXI4-Lite write response
   output logic [1:0]                s_axi_bresp,     // Write response
   output logic                      s_axi_bvalid,    // Write response valid
   input  wire logic                 s_axi_bready,    // Write response ready
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,    // Read address
   input  wire logic                 s_axi_arvalid,   // Read address valid
   output logic                      s_axi_arready,   // Read address ready
   // AXI4-Lite read data
   output logic [31:0]               s_axi_rdata,     // Read data
   output logic [1:0]                s_axi_rresp,     // Read response
   output logic                      s_axi_rvalid,    // Read data valid
   input  wire logic                 s_axi_rready,    // Read data ready
   // Power mode from the power controller
   input  wire logic                 sleep_mode,      // Device is in sleep
   input  wire logic                 deep_sleep_mode, // Device is in deep-sleep
   // Unit access check
   input  wire logic                 periph_req,      // Access to a unit, one cycle
   input  wire logic [2:0]           periph_sel,      // Index of the accessed unit
   output logic                      periph_resp_valid, // Access answered
   output logic                      periph_resp_fault, // Answer is a bus fault
   // Unit clock enables
   output logic [NUM_UNITS-1:0]      unit_clk_en      // Clock enable per unit
);

   //--------------------------------------------------------------
   // Elaboration checks
   //--------------------------------------------------------------
   // Unserviceable parameter values stop elaboration
   if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
      $error("dscg_top: ADDR_W must be 12 to 32");
   end
   if (NUM_UNITS != `DSCG_NUM_UNITS) begin : g_bad_num_units
      $error("dscg_top: NUM_UNITS must match the gate bit table");
   end

   //--------------------------------------------------------------
   // Declarations
   //--------------------------------------------------------------
   logic [31:0]         run_gate_reg;
   logic [31:0]         sleep_gate_reg;
   logic [31:0]         deep_sleep_gate_reg;
   logic [31:0]         run_clock_config_reg;
   logic [ADDR_W-1:0]   aw_addr_reg;
   logic                aw_held_reg;
   logic [31:0]         w_data_reg;
   logic [3:0]          w_strb_reg;
   logic                w_held_reg;
   logic                do_write;
   logic [31:0]         wmask;
   logic                wr_hit;
   logic [31:0]         rd_data_next;
   logic                rd_hit;
   dscg_mode_t          mode_reg;
   logic                auto_clock_gate_select;
   logic [NUM_UNITS-1:0] unit_access;
   logic [NUM_UNITS-1:0] unit_fault;

   // Bit position of each unit in the gate registers
   function automatic int unit_bit(input int idx);
      case (idx)
         0:       unit_bit = `DSCG_BIT_ASYNC_SERIAL_ZERO;
         1:       unit_bit = `DSCG_BIT_ASYNC_SERIAL_ONE;
         2:       unit_bit = `DSCG_BIT_SYNC_SERIAL_ZERO;
         3:       unit_bit = `DSCG_BIT_TWO_WIRE_ZERO;
         4:       unit_bit = `DSCG_BIT_GP_TIMER_ZERO;
         default: unit_bit = `DSCG_BIT_GP_TIMER_ONE;
      endcase
   endfunction

   //--------------------------------------------------------------
   // Write channel capture
   //--------------------------------------------------------------

   // Address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   // Ready drops once a beat is held, returns after the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write performed when both halves are held
   assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

   // Byte strobes expanded to a bit mask
   always_comb begin
      wmask = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{w_strb_reg[b]}};
      end
   end

   // Write address decode
   always_comb begin
      wr_hit = 1'b0;
      if (aw_addr_reg[11:0] == `DSCG_OFF_DEEP_SLEEP_GATE) begin
         wr_hit = 1'b1;
      end else if (aw_addr_reg[11:0] == `DSCG_OFF_SLEEP_GATE) begin
         wr_hit = 1'b1;
      end else if (aw_addr_reg[11:0] == `DSCG_OFF_RUN_GATE) begin
         wr_hit = 1'b1;
      end else if (aw_addr_reg[11:0] == `DSCG_OFF_RUN_CLOCK_CONFIG) begin
         wr_hit = 1'b1;
      end
      if (ADDR_W > 12 && (aw_addr_reg >> 12) != '0) begin
         wr_hit = 1'b0;
      end
   end

   //--------------------------------------------------------------
   // Registers
   //--------------------------------------------------------------

   // Deep-sleep gate register, reserved bits stay zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         deep_sleep_gate_reg <= `DSCG_GATE_RESET;
      end else if (do_write && wr_hit && aw_addr_reg[11:0] == `DSCG_OFF_DEEP_SLEEP_GATE) begin
         deep_sleep_gate_reg <= ((deep_sleep_gate_reg & ~wmask) | (w_data_reg & wmask))
                                & `DSCG_GATE_MASK;
      end
   end

   // Sleep gate register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_gate_reg <= `DSCG_GATE_RESET;
      end else if (do_write && wr_hit && aw_addr_reg[11:0] == `DSCG_OFF_SLEEP_GATE) begin
         sleep_gate_reg <= ((sleep_gate_reg & ~wmask) | (w_data_reg & wmask)) & `DSCG_GATE_MASK;
      end
   end

   // Run gate register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_gate_reg <= `DSCG_GATE_RESET;
      end else if (do_write && wr_hit && aw_addr_reg[11:0] == `DSCG_OFF_RUN_GATE) begin
         run_gate_reg <= ((run_gate_reg & ~wmask) | (w_data_reg & wmask)) & `DSCG_GATE_MASK;
      end
   end

   // Run clock configuration, only automatic gating held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_clock_config_reg <= `DSCG_CONFIG_RESET;
      end else if (do_write && wr_hit && aw_addr_reg[11:0] == `DSCG_OFF_RUN_CLOCK_CONFIG) begin
         run_clock_config_reg <= ((run_clock_config_reg & ~wmask) | (w_data_reg & wmask))
                                 & `DSCG_CONFIG_MASK;
      end
   end

   assign auto_clock_gate_select = run_clock_config_reg[`DSCG_BIT_AUTO_CLOCK_GATE];

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DSCG_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `DSCG_RESP_OKAY : `DSCG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   //--------------------------------------------------------------
   // Read channel
   //--------------------------------------------------------------

   // Read address decode, reserved bits read zero
   always_comb begin
      rd_hit       = 1'b1;
      rd_data_next = 32'h0000_0000;
      if (s_axi_araddr[11:0] == `DSCG_OFF_DEEP_SLEEP_GATE) begin
         rd_data_next = deep_sleep_gate_reg;
      end else if (s_axi_araddr[11:0] == `DSCG_OFF_SLEEP_GATE) begin
         rd_data_next = sleep_gate_reg;
      end else if (s_axi_araddr[11:0] == `DSCG_OFF_RUN_GATE) begin
         rd_data_next = run_gate_reg;
      end else if (s_axi_araddr[11:0] == `DSCG_OFF_RUN_CLOCK_CONFIG) begin
         rd_data_next = run_clock_config_reg;
      end else begin
         rd_hit = 1'b0;
      end
      if (ADDR_W > 12 && (s_axi_araddr >> 12) != '0) begin
         rd_hit       = 1'b0;
         rd_data_next = 32'h0000_0000;
      end
   end

   // Read ready returns after the data beat
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Read data one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `DSCG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data_next;
         s_axi_rresp  <= rd_hit ? `DSCG_RESP_OKAY : `DSCG_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   //--------------------------------------------------------------
   // Power mode and unit gating
   //--------------------------------------------------------------

   // Current mode, deep-sleep wins over sleep
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= DSCG_MODE_RUN;
      end else if (deep_sleep_mode) begin
         mode_reg <= DSCG_MODE_DEEP;
      end else if (sleep_mode) begin
         mode_reg <= DSCG_MODE_SLEEP;
      end else begin
         mode_reg <= DSCG_MODE_RUN;
      end
   end

   // One gate per unit
   generate
      for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
         assign unit_access[u] = periph_req & (periph_sel == 3'(u));
         dscg_gate_unit u_gate (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .run_bit   (run_gate_reg[unit_bit(u)]),
            .sleep_bit (sleep_gate_reg[unit_bit(u)]),
            .deep_bit  (deep_sleep_gate_reg[unit_bit(u)]),
            .mode      (mode_reg),
            .auto_gate (auto_clock_gate_select),
            .access    (unit_access[u]),
            .clk_en    (unit_clk_en[u]),
            .fault     (unit_fault[u])
         );
      end
   endgenerate

   // Access answer one cycle after the request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_resp_valid <= 1'b0;
         periph_resp_fault <= 1'b0;
      end else begin
         periph_resp_valid <= periph_req;
         periph_resp_fault <= periph_req & ((|unit_fault) | (periph_sel >= 3'(NUM_UNITS)));
      end
   end

endmodule

/* File: src/dscg_defs.svh */
// Offsets, field positions, reset values and response codes of the
// deep-sleep clock gating block. Included by the top, checker and bench.
`ifndef DSCG_DEFS_SVH
`define DSCG_DEFS_SVH

// Register byte offsets
`define DSCG_OFF_RUN_CLOCK_CONFIG 12'h060
`define DSCG_OFF_RUN_GATE         12'h104
`define DSCG_OFF_SLEEP_GATE       12'h114
`define DSCG_OFF_DEEP_SLEEP_GATE  12'h124

// Gate bit positions and the run clock configuration bit
`define DSCG_BIT_ASYNC_SERIAL_ZERO 0
`define DSCG_BIT_ASYNC_SERIAL_ONE  1
`define DSCG_BIT_SYNC_SERIAL_ZERO  4
`define DSCG_BIT_TWO_WIRE_ZERO     12
`define DSCG_BIT_GP_TIMER_ZERO     16
`define DSCG_BIT_GP_TIMER_ONE      17
`define DSCG_BIT_AUTO_CLOCK_GATE   27

// Writable masks and reset values
`define DSCG_GATE_MASK   32'h0003_1013
`define DSCG_CONFIG_MASK 32'h0800_0000
`define DSCG_GATE_RESET  32'h0000_0000
`define DSCG_CONFIG_RESET 32'h0000_0000

// Number of gated units
`define DSCG_NUM_UNITS 6

// AXI responses
`define DSCG_RESP_OKAY   2'h0
`define DSCG_RESP_SLVERR 2'h2

`endif

/* File: src/dscg_pkg.sv */
// Types shared by the deep-sleep clock gating block.
// Assumes dscg_defs.svh is on the include path.
package dscg_pkg;
   // Power mode of the device
   typedef enum logic [1:0] {
      DSCG_MODE_RUN,
      DSCG_MODE_SLEEP,
      DSCG_MODE_DEEP
   } dscg_mode_t;
endpackage

/* File: src/dscg_gate_unit.sv */
// One gated unit: picks its clock enable from the register of the
// current power mode when automatic gating is selected, else from the
// run register, and flags accesses made while unclocked.
// Assumes mode and register bits come from logic on the same clock.
`timescale 1ns/1ps
module dscg_gate_unit
   import dscg_pkg::*;
(
   input  wire logic       aclk,      // System clock
   input  wire logic       aresetn,   // Synchronous reset, active low
   input  wire logic       run_bit,   // Run-mode gate bit
   input  wire logic       sleep_bit, // Sleep-mode gate bit
   input  wire logic       deep_bit,  // Deep-sleep gate bit
   input  wire dscg_mode_t mode,      // Current power mode
   input  wire logic       auto_gate, // Automatic gating selected
   input  wire logic       access,    // Access aimed at this unit
   output logic            clk_en,    // Unit clock enable
   output logic            fault      // Access to an unclocked unit
);

   logic en_next;

   // Source of the enable for each mode
   always_comb begin
      en_next = run_bit;
      case (mode)
         DSCG_MODE_RUN: begin
            en_next = run_bit;
         end
         DSCG_MODE_SLEEP: begin
            en_next = auto_gate ? sleep_bit : run_bit;
         end
         DSCG_MODE_DEEP: begin
            en_next = auto_gate ? deep_bit : run_bit;
         end
         default: begin
            en_next = run_bit;
         end
      endcase
   end

   // Enable flop, cleared by reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_en <= 1'b0;
      end else begin
         clk_en <= en_next;
      end
   end

   // Fault while the unit is unclocked
   assign fault = access & ~clk_en;

endmodule

/* File: verification/dscg_top_assertions.sv */
// Checker of the deep-sleep clock gating top: bus, enable and fault timing.
// Assumes it is bound to dscg_top and sees only that module's ports.
`timescale 1ns/1ps
`include "dscg_defs.svh"
module dscg_top_checker
   import dscg_pkg::*;
#(
   parameter int ADDR_W    = 12, // Address width
   parameter int NUM_UNITS = 6   // Gated units
)
(
   input wire logic                 aclk,              // Clock
   input wire logic                 aresetn,           // Reset, low
   input wire logic [ADDR_W-1:0]    s_axi_awaddr,      // AW addr
   input wire logic                 s_axi_awvalid,     // AW valid
   input wire logic                 s_axi_awready,     // AW ready
   input wire logic [31:0]          s_axi_wdata,       // W data
   input wire logic [3:0]           s_axi_wstrb,       // W strobes
   input wire logic                 s_axi_wvalid,      // W valid
   input wire logic                 s_axi_wready,      // W ready
   input wire logic [1:0]           s_axi_bresp,       // B resp
   input wire logic                 s_axi_bvalid,      // B valid
   input wire logic                 s_axi_bready,      // B ready
   input wire logic [ADDR_W-1:0]    s_axi_araddr,      // AR addr
   input wire logic                 s_axi_arvalid,     // AR valid
   input wire logic                 s_axi_arready,     // AR ready
   input wire logic [31:0]          s_axi_rdata,       // R data
   input wire logic [1:0]           s_axi_rresp,       // R resp
   input wire logic                 s_axi_rvalid,      // R valid
   input wire logic                 s_axi_rready,      // R ready
   input wire logic                 sleep_mode,        // Sleep
   input wire logic                 deep_sleep_mode,   // Deep-sleep
   input wire logic                 periph_req,        // Unit access
   input wire logic [2:0]           periph_sel,        // Unit index
   input wire logic                 periph_resp_valid, // Access answered
   input wire logic                 periph_resp_fault, // Fault answer
   input wire logic [NUM_UNITS-1:0] unit_clk_en        // Enables
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_reset_clear; $rose(aresetn) |-> unit_clk_en == '0 && !s_axi_bvalid && !s_axi_rvalid; endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
   property p_clocked_ok; periph_req && periph_sel < 3'h6 && unit_clk_en[periph_sel] |=>
      periph_resp_valid && !periph_resp_fault; endproperty
   a_clocked_ok: assert property (p_clocked_ok) else $error("clocked unit answered with a fault");
   property p_gated_fault; periph_req && (periph_sel >= 3'h6 || !unit_clk_en[periph_sel]) |=>
      periph_resp_valid && periph_resp_fault; endproperty
   a_gated_fault: assert property (p_gated_fault) else $error("gated unit access not faulted");
   property p_no_req; !periph_req |=> !periph_resp_valid; endproperty
   a_no_req: assert property (p_no_req) else $error("access answer without access");
   // Enables move only after a mode change, a register write or a reset
   property p_en_cause; $changed(unit_clk_en) |-> $past(sleep_mode) != $past(sleep_mode, 3)
      || $past(deep_sleep_mode) != $past(deep_sleep_mode, 3) || $past(s_axi_bvalid)
      || $past(s_axi_bvalid, 2) || !$past(aresetn, 2) || !$past(aresetn, 3); endproperty
   a_en_cause: assert property (p_en_cause) else $error("enables changed without cause");
   property p_write_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      !s_axi_bvalid ##1 s_axi_bvalid; endproperty
   a_write_answer: assert property (p_write_answer) else $error("write answer mistimed");
   property p_write_busy; $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready; endproperty
   a_write_busy: assert property (p_write_busy) else $error("write channels ready during answer");
   property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer mistimed");
   property p_unmapped_read; s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {`DSCG_OFF_RUN_CLOCK_CONFIG,
      `DSCG_OFF_RUN_GATE, `DSCG_OFF_SLEEP_GATE, `DSCG_OFF_DEEP_SLEEP_GATE}) |=>
      s_axi_rresp == `DSCG_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");
   property p_deep_read; s_axi_arvalid && s_axi_arready && s_axi_araddr == `DSCG_OFF_DEEP_SLEEP_GATE |=>
      s_axi_rresp == `DSCG_RESP_OKAY; endproperty
   a_deep_read: assert property (p_deep_read) else $error("deep-sleep gate read refused");
   property p_reserved_zero; s_axi_rvalid |-> (s_axi_rdata & ~(`DSCG_GATE_MASK | `DSCG_CONFIG_MASK)) == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
endmodule

bind dscg_top dscg_top_checker #(.ADDR_W(ADDR_W), .NUM_UNITS(NUM_UNITS)) dscg_top_checker_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode), .periph_req(periph_req),
   .periph_sel(periph_sel), .periph_resp_valid(periph_resp_valid), .periph_resp_fault(periph_resp_fault),
   .unit_clk_en(unit_clk_en));

/* File: verification/dscg_top_bench.sv */
// Self-checking bench of the deep-sleep clock gating top.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`include "dscg_defs.svh"
module dscg_top_bench
   import dscg_pkg::*;
;
   typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] x; logic [1:0] p;} dscg_row_t;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, sleep = 1'b0, deep = 1'b0, req = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [2:0] sel = 3'h0;
   logic awready, wready, bvalid, arready, rvalid, resp_valid, resp_fault, f;
   logic [1:0] bresp, rresp, r;
   logic [5:0] en;
   int fails = 0, total_checks = 0;
   int bitpos [6] = '{0, 1, 4, 12, 16, 17};
   // Address, write value, read-back value, response
   dscg_row_t rows [6] = '{'{12'h124, 32'hFFFF_FFFF, 32'h0003_1013, 2'h0},
      '{12'h104, 32'hFFFF_FFFF, 32'h0003_1013, 2'h0}, '{12'h114, 32'h0000_0011, 32'h0000_0011, 2'h0},
      '{12'h060, 32'hFFFF_FFFF, 32'h0800_0000, 2'h0}, '{12'h128, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2},
      '{12'h126, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2}};

   dscg_top dscg_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_mode(sleep),
      .deep_sleep_mode(deep), .periph_req(req), .periph_sel(sel), .periph_resp_valid(resp_valid),
      .periph_resp_fault(resp_fault), .unit_clk_en(en));

   // Clock, 40 ns period
   always #20 aclk = ~aclk;

   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            rsp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            v = rdata;
            rsp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // One unit access, answer sampled the cycle after
   task automatic hit(input logic [2:0] s, output logic flt);
      @(posedge aclk);
      req <= 1'b1;
      sel <= s;
      @(posedge aclk);
      req <= 1'b0;
      @(posedge aclk);
      check(32'(resp_valid), 32'h1);
      flt = resp_fault;
   endtask

   task automatic settle();
      repeat (3) @(posedge aclk);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      complete_run();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h124, d, r);
      check(d, 32'h0);
      check(32'(en), 32'h0);
      hit(3'h0, f);
      check(32'(f), 32'h1);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w, r);
         check(32'(r), 32'(rows[i].p));
         rd(rows[i].a, d, r);
         check(32'(r), 32'(rows[i].p));
         check(d, rows[i].x);
      end
      $display("test table done");
      settle();
      check(32'(en), 32'h3F);
      hit(3'h5, f);
      check(32'(f), 32'h0);
      hit(3'h6, f);
      check(32'(f), 32'h1);
      // Read-modify-write keeps reserved bits, sets the deep-sleep units
      rd(12'h124, d, r);
      wr(12'h124, (d & ~32'h0003_1013) | 32'h0001_0001, r);
      check(32'(r), 32'h0);
      settle();
      check(32'(en), 32'h3F);
      rd(12'h124, d, r);
      check(d, 32'h0001_0001);
      deep <= 1'b1;
      settle();
      check(32'(en), 32'h11);
      hit(3'h1, f);
      check(32'(f), 32'h1);
      hit(3'h4, f);
      check(32'(f), 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr(12'h124, 32'h1 << bitpos[i], r);
         settle();
         check(32'(en), 32'h1 << i);
      end
      $display("test deep done");
      sleep <= 1'b1;
      deep <= 1'b0;
      settle();
      check(32'(en), 32'h05);
      wr(12'h060, 32'h0, r);
      settle();
      check(32'(en), 32'h3F);
      deep <= 1'b1;
      settle();
      check(32'(en), 32'h3F);
      $display("test auto done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h124, d, r);
      check(d, 32'h0);
      check(32'(en), 32'h0);
      $display("test second reset done");
      complete_run();
   end
endmodule
